/* hw/stpwm_map.svh */
// register offsets, field positions and reset values of the pwm block
// assumes an 8-bit register port; included by bare name
`ifndef STPWM_MAP_SVH
`define STPWM_MAP_SVH

// offsets of the shared registers
`define STPWM_ADDR_PERIOD   8'h00
`define STPWM_ADDR_TCTL     8'h01
`define STPWM_ADDR_COUNT    8'h02
`define STPWM_ADDR_DIR      8'h03
// channel window: base 8'h08, one 4-byte slot per channel
`define STPWM_CH_BASE_HI    5'h01
`define STPWM_FLD_DUTY_HIGH 2'h0
`define STPWM_FLD_DUTY_LOW  2'h1
`define STPWM_FLD_CTL       2'h2

// field positions
`define STPWM_CTL_EN_BIT    7
`define STPWM_CTL_OUT_BIT   5
`define STPWM_CTL_INV_BIT   4
`define STPWM_DUTYL_MSB     7
`define STPWM_DUTYL_LSB     6
`define STPWM_TCTL_ON_BIT   0
`define STPWM_TCTL_PS_LSB   1
`define STPWM_TCTL_PS_MSB   2
`define STPWM_TCTL_POST_LSB 3
`define STPWM_TCTL_POST_MSB 6

// reset values
`define STPWM_RST_PERIOD    8'hff
`define STPWM_RST_TCTL      8'h00
`define STPWM_RST_DUTY      10'h000
`define STPWM_RST_DIR       2'h3

// timing: four sub-steps per counter increment
`define STPWM_SUB_LAST      2'h3
`define STPWM_SUB_STEPS     11'h004

`endif

/* hw/stpwm_pkg.sv */
// types and helpers shared by the pwm block files
// assumes stpwm_map.svh for the numeric constants
`default_nettype none
package stpwm_pkg;

  typedef logic [7:0] stpwm_byte_t;
  typedef logic [9:0] stpwm_duty_t;

  // prescale ratio select
  typedef enum logic [1:0] {
    PS_1,
    PS_4,
    PS_16,
    PS_64
  } stpwm_ps_e;

  // last prescaler count for a ratio
  function automatic logic [5:0] ps_last(input stpwm_ps_e ps);
    unique case (ps)
      PS_1:  ps_last = 6'h00;
      PS_4:  ps_last = 6'h03;
      PS_16: ps_last = 6'h0f;
      PS_64: ps_last = 6'h3f;
    endcase
  endfunction

  // join high byte and two low bits into one duty word
  function automatic stpwm_duty_t duty_join(input stpwm_byte_t hi,
                                            input logic [1:0] lo);
    duty_join = {hi, lo};
  endfunction

endpackage
`default_nettype wire

/* hw/stpwm_timebase.sv */
// shared 10-bit time base: 8-bit period counter plus two sub-count bits
// assumes one clock; run and clock enable come from the top
`include "stpwm_map.svh"
`default_nettype none
module stpwm_timebase (
  input  wire logic                  i_core_clk,
  input  wire logic                  i_arst_n,
  input  wire logic                  i_clk_en,
  input  wire logic                  i_run,
  input  wire stpwm_pkg::stpwm_ps_e  i_ps,
  input  wire stpwm_pkg::stpwm_byte_t i_period,
  input  wire logic                  i_load,
  input  wire stpwm_pkg::stpwm_byte_t i_load_val,
  output logic [9:0]                 o_tb,
  output logic                       o_match
);

  logic [5:0]             pre_reg;
  logic [1:0]             sub_reg;
  stpwm_pkg::stpwm_byte_t cnt_reg;
  logic                   step;

  // one quarter step per prescale ratio of core cycles
  assign step    = i_run && (pre_reg == stpwm_pkg::ps_last(i_ps)); // R14
  assign o_match = step && (sub_reg == `STPWM_SUB_LAST)
                   && (cnt_reg == i_period); // R8
  assign o_tb    = {cnt_reg, sub_reg}; // R14

  // prescaler, sub-count and counter; the postscaler plays no part R3
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pre_reg <= 6'h00;
      sub_reg <= 2'h0;
      cnt_reg <= 8'h00;
    end else if (i_clk_en) begin
      if (i_load) begin
        pre_reg <= 6'h00;
        sub_reg <= 2'h0;
        cnt_reg <= i_load_val;
      end else if (i_run) begin
        pre_reg <= step ? 6'h00 : pre_reg + 6'h01;
        if (step) begin
          sub_reg <= sub_reg + 2'h1;
          if (sub_reg == `STPWM_SUB_LAST) begin
            cnt_reg <= o_match ? 8'h00 : cnt_reg + 8'h01; // R8 R11
          end
        end
      end
    end
  end

endmodule
`default_nettype wire

/* hw/stpwm_top.sv */
// two-channel 10-bit pwm on a shared period counter, register port
// assumes core clock is the oscillator; sleep is a level from outside
//
// Function
// R1: each output has 10-bit duty, timed only by the shared counter.
// R2: period shared by all channels; each channel has its own duty.
// R3: the postscaler never influences frequency or waveform.
// R4: outputs go active when the shared counter clears for a new period.
// R5: output goes inactive when time base equals the channel duty.
// R6: duty at or beyond the period keeps the output active; beyond it the code holds the previous level instead.
// R7: duty parts are double buffered, loaded only at period match.
// R8: at match the next step clears counter, sets output, loads buffers.
// R9: zero duty keeps the output inactive at period start.
// R10: invert bit set inverts the output, clear gives normal.
// R11: period is (match value + 1) x 4 x oscillator x prescale.
// R12: software picks a quarter of the oscillator as counter clock.
// R13: duty high byte and low bits 7:6 writable at any time.
// R14: counter extended by two sub-count bits from oscillator or prescaler.
// R15: full ten-bit resolution only when match value is 255.
// R16: pulse width is duty x oscillator period x prescale ratio.
// R17: pulse width beyond the period leaves the pins unchanged.
// R18: sleep stops the counter, freezes state, holds the output level.
// R19: any reset restores register values and makes pins inputs.
// R20: software writes both duty parts before the next match.
// R21: software clears the pin direction bit to show the waveform.
// R22: a channel runs only while its enable bit is set.
// R23: reading the output-level bit returns the present output level.
// R24: a disabled channel sits inactive, inversion still applied.
//
// Added by the designer: the address map and strobed register access.
`include "stpwm_map.svh"
`default_nettype none
module stpwm_top (
  input  wire logic       i_core_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_clk_en,
  input  wire logic       i_sleep,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  output logic      [1:0] o_pwm,
  output logic      [1:0] o_pin_oe_n
);

  localparam int NCH = 2;
  // reset image of the timer control byte, on bit picked out below
  localparam stpwm_pkg::stpwm_byte_t RST_TCTL = `STPWM_RST_TCTL;

  // shared registers
  stpwm_pkg::stpwm_byte_t period_match_value_reg;
  logic                   timer_on_reg;
  stpwm_pkg::stpwm_ps_e   prescale_reg;
  logic [3:0]             postscale_reg;
  logic [1:0]             pin_direction_reg;

  // per-channel registers and state
  stpwm_pkg::stpwm_byte_t duty_high_byte_reg [NCH];
  logic [1:0]             duty_low_bits_reg  [NCH];
  stpwm_pkg::stpwm_duty_t duty_buf_reg       [NCH];
  logic [NCH-1:0]         enable_reg;
  logic [NCH-1:0]         output_invert_reg;
  logic [NCH-1:0]         level_reg;
  logic [NCH-1:0]         level_next;
  logic [NCH-1:0]         level_shown;

  // decode and time base wires
  logic [9:0]             tb;
  logic                   match;
  logic                   run;
  logic                   wrap;
  logic                   ch_hit;
  logic                   ch_sel;
  logic                   count_load;
  logic [10:0]            period_len;
  logic [7:0]             rdata_next;

  // counter advances only when switched on and awake R18
  assign run  = i_clk_en && !i_sleep && timer_on_reg;
  assign wrap = run && match;

  // period length in quarter steps, used for full and over-range duty
  assign period_len = ({3'h0, period_match_value_reg} + 11'h001) << 2;

  // channel window decode
  assign ch_hit = (i_addr[7:3] == `STPWM_CH_BASE_HI);
  assign ch_sel = i_addr[2];

  assign count_load = i_wr && (i_addr == `STPWM_ADDR_COUNT);

  // shared period counter
  stpwm_timebase u_timebase (
    .i_core_clk (i_core_clk),
    .i_arst_n   (i_arst_n),
    .i_clk_en   (i_clk_en),
    .i_run      (!i_sleep && timer_on_reg),
    .i_ps       (prescale_reg),
    .i_period   (period_match_value_reg),
    .i_load     (count_load),
    .i_load_val (i_wdata),
    .o_tb       (tb),
    .o_match    (match)
  );

  // shared register writes; postscale is stored only, never used R3
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      period_match_value_reg <= `STPWM_RST_PERIOD; // R19
      timer_on_reg  <= RST_TCTL[`STPWM_TCTL_ON_BIT];
      prescale_reg  <= stpwm_pkg::PS_1;
      postscale_reg <= 4'h0;
    end else if (i_clk_en && i_wr) begin
      if (i_addr == `STPWM_ADDR_PERIOD) begin
        period_match_value_reg <= i_wdata; // R2
      end
      if (i_addr == `STPWM_ADDR_TCTL) begin
        timer_on_reg  <= i_wdata[`STPWM_TCTL_ON_BIT];
        prescale_reg  <= stpwm_pkg::stpwm_ps_e'(
          i_wdata[`STPWM_TCTL_PS_MSB:`STPWM_TCTL_PS_LSB]);
        postscale_reg <= i_wdata[`STPWM_TCTL_POST_MSB:`STPWM_TCTL_POST_LSB];
      end
    end
  end

  // pin direction: reset forces every pin to input R19
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_direction_reg <= `STPWM_RST_DIR; // R19
    end else if (i_clk_en && i_wr && i_addr == `STPWM_ADDR_DIR) begin
      pin_direction_reg <= i_wdata[1:0];
    end
  end

  // pin drive follows the direction bits one cycle later R21
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pin_oe_n <= `STPWM_RST_DIR;
    end else if (i_clk_en) begin
      o_pin_oe_n <= pin_direction_reg;
    end
  end

  // duty shadow and control writes, accepted at any moment R13
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int c = 0; c < NCH; c++) begin
        duty_high_byte_reg[c] <= 8'(`STPWM_RST_DUTY >> 2);
        duty_low_bits_reg[c]  <= 2'h0;
      end
      enable_reg        <= '0;
      output_invert_reg <= '0;
    end else if (i_clk_en && i_wr && ch_hit) begin
      unique case (i_addr[1:0])
        `STPWM_FLD_DUTY_HIGH: duty_high_byte_reg[ch_sel] <= i_wdata; // R13
        `STPWM_FLD_DUTY_LOW: begin
          duty_low_bits_reg[ch_sel] <=
            i_wdata[`STPWM_DUTYL_MSB:`STPWM_DUTYL_LSB]; // R13
        end
        `STPWM_FLD_CTL: begin
          enable_reg[ch_sel]        <= i_wdata[`STPWM_CTL_EN_BIT];
          output_invert_reg[ch_sel] <= i_wdata[`STPWM_CTL_INV_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // active buffers change only at the period match, so no glitch
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int c = 0; c < NCH; c++) begin
        duty_buf_reg[c] <= `STPWM_RST_DUTY;
      end
    end else if (wrap) begin
      for (int c = 0; c < NCH; c++) begin
        duty_buf_reg[c] <= stpwm_pkg::duty_join(duty_high_byte_reg[c],
                                                duty_low_bits_reg[c]); // R7
      end
    end
  end

  // waveform per channel: set at wrap, clear on compare
  always_comb begin
    stpwm_pkg::stpwm_duty_t nd;
    nd = '0;
    level_next = level_reg;
    for (int c = 0; c < NCH; c++) begin
      nd = stpwm_pkg::duty_join(duty_high_byte_reg[c], duty_low_bits_reg[c]);
      if (!enable_reg[c]) begin
        level_next[c] = 1'b0; // R22 R24
      end else if (wrap) begin
        if (nd == 10'h000) begin
          level_next[c] = 1'b0; // R9
        end else if ({1'b0, nd} > period_len) begin
          level_next[c] = level_reg[c]; // R17
        end else begin
          level_next[c] = 1'b1; // R4 R8
        end
      end else if (run && tb == duty_buf_reg[c]) begin
        level_next[c] = 1'b0; // R5 R16
      end
    end
  end

  // a duty at or past the period never meets the time base R6 R15
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      level_reg <= '0;
    end else if (i_clk_en && !i_sleep) begin
      level_reg <= level_next; // R1 R18
    end
  end

  // level hidden in the cycle the time base meets the duty; the
  // registered compare alone would stretch every pulse by one cycle
  always_comb begin
    level_shown = level_reg;
    for (int c = 0; c < NCH; c++) begin
      if (tb == duty_buf_reg[c]) begin
        level_shown[c] = 1'b0; // R5 R16
      end
    end
  end

  // polarity applied last, so disabled channels sit at inverse too
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pwm <= '0;
    end else if (i_clk_en && !i_sleep) begin
      o_pwm <= level_shown ^ output_invert_reg; // R10 R24
    end
  end

  // read mux; unmapped offsets return zero
  always_comb begin
    rdata_next = 8'h00;
    if (ch_hit) begin
      unique case (i_addr[1:0])
        `STPWM_FLD_DUTY_HIGH: rdata_next = duty_high_byte_reg[ch_sel];
        `STPWM_FLD_DUTY_LOW: begin
          rdata_next[`STPWM_DUTYL_MSB:`STPWM_DUTYL_LSB] =
            duty_low_bits_reg[ch_sel];
        end
        `STPWM_FLD_CTL: begin
          rdata_next[`STPWM_CTL_EN_BIT]  = enable_reg[ch_sel];
          rdata_next[`STPWM_CTL_OUT_BIT] = o_pwm[ch_sel]; // R23
          rdata_next[`STPWM_CTL_INV_BIT] = output_invert_reg[ch_sel];
        end
        default: rdata_next = 8'h00;
      endcase
    end else begin
      unique case (i_addr)
        `STPWM_ADDR_PERIOD: rdata_next = period_match_value_reg;
        `STPWM_ADDR_TCTL: begin
          rdata_next[`STPWM_TCTL_ON_BIT] = timer_on_reg;
          rdata_next[`STPWM_TCTL_PS_MSB:`STPWM_TCTL_PS_LSB] = prescale_reg;
          rdata_next[`STPWM_TCTL_POST_MSB:`STPWM_TCTL_POST_LSB] =
            postscale_reg;
        end
        `STPWM_ADDR_COUNT: rdata_next = tb[9:2];
        `STPWM_ADDR_DIR:   rdata_next = {6'h00, pin_direction_reg};
        default:           rdata_next = 8'h00;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rdata <= 8'h00;
    end else if (i_clk_en) begin
      o_rdata <= i_rd ? rdata_next : 8'h00;
    end
  end

  // checks on the waveform and register behaviour
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);

  sequence s_wrap;
    wrap;
  endsequence

  sequence s_wrap_zero0;
    wrap && enable_reg[0] && duty_high_byte_reg[0] == 8'h00
      && duty_low_bits_reg[0] == 2'h0;
  endsequence

  sequence s_wrap_set0;
    wrap && enable_reg[0]
      && {duty_high_byte_reg[0], duty_low_bits_reg[0]} != 10'h000
      && {1'b0, duty_high_byte_reg[0], duty_low_bits_reg[0]}
         <= period_len;
  endsequence

  counter_clear_a: assert property ( // R8
    s_wrap |=> tb == 10'h000)
    else $error("time base not cleared after period match");

  buffer_load_a: assert property ( // R7
    s_wrap |=> duty_buf_reg[0] == $past({duty_high_byte_reg[0],
                                          duty_low_bits_reg[0]}))
    else $error("duty buffer not loaded at period match");

  buffer_hold_a: assert property ( // R7
    !wrap |=> $stable(duty_buf_reg[1]))
    else $error("duty buffer changed away from period match");

  period_set_a: assert property ( // R4
    s_wrap_set0 ##1 (i_clk_en && !i_sleep)
      |-> level_reg[0] ##1 o_pwm[0] == !$past(output_invert_reg[0]))
    else $error("output not active at period start");

  zero_duty_a: assert property ( // R9
    s_wrap_zero0 |=> !level_reg[0])
    else $error("zero duty drove output active");

  over_range_a: assert property ( // R17
    wrap && enable_reg[0] && {1'b0, duty_high_byte_reg[0],
      duty_low_bits_reg[0]} > period_len |=> $stable(level_reg[0]))
    else $error("over-range duty changed the output level");

  compare_clear_a: assert property ( // R5
    run && !wrap && enable_reg[0] && tb == duty_buf_reg[0]
      |=> !level_reg[0])
    else $error("output not cleared on duty compare");

  polarity_out_a: assert property ( // R10
    i_clk_en && !i_sleep
      |=> o_pwm[1] == ($past(level_shown[1]) ^ $past(output_invert_reg[1])))
    else $error("output polarity wrong");

  sleep_freeze_a: assert property ( // R18
    i_sleep |=> $stable(tb) && $stable(level_reg) && $stable(o_pwm))
    else $error("state moved during sleep");

  disable_idle_a: assert property ( // R24
    !enable_reg[0] && i_clk_en && !i_sleep ##1 i_clk_en && !i_sleep
      |=> o_pwm[0] == $past(output_invert_reg[0]))
    else $error("disabled channel not at inactive level");

  out_read_a: assert property ( // R23
    i_rd && i_clk_en && ch_hit && !ch_sel && i_addr[1:0] == `STPWM_FLD_CTL
      |=> o_rdata[`STPWM_CTL_OUT_BIT] == $past(o_pwm[0]))
    else $error("output level bit reads wrong");

endmodule
`default_nettype wire

/* bench/stpwm_top_bench.sv */
// self-checking bench for the two-channel pwm block
// assumes a 20 MHz core clock and the register map of stpwm_map.svh
`include "stpwm_map.svh"
`default_nettype none
module stpwm_top_bench;
  timeunit 1ns;
  timeprecision 1ps;

  logic       i_core_clk;
  logic       i_arst_n;
  logic       i_clk_en;
  logic       i_sleep;
  logic [7:0] i_addr;
  logic [7:0] i_wdata;
  logic       i_wr;
  logic       i_rd;
  logic [7:0] o_rdata;
  logic [1:0] o_pwm;
  logic [1:0] o_pin_oe_n;
  int         n_mismatch;
  int         n_checks;
  int         cycles = 0;
  integer     seed;
  // model state: duty, invert and enable per channel
  int         duty [2];
  int         inv  [2];
  int         en   [2];
  int         per_p;
  int         ps_n;
  integer     hi_c [2];
  integer     tr_c [2];
  logic [7:0] rv;
  logic [7:0] rv2;

  stpwm_top stpwm_top_inst (
    .i_core_clk (i_core_clk),
    .i_arst_n   (i_arst_n),
    .i_clk_en   (i_clk_en),
    .i_sleep    (i_sleep),
    .i_addr     (i_addr),
    .i_wdata    (i_wdata),
    .i_wr       (i_wr),
    .i_rd       (i_rd),
    .o_rdata    (o_rdata),
    .o_pwm      (o_pwm),
    .o_pin_oe_n (o_pin_oe_n)
  );

  initial begin
    i_core_clk = 1'b0;
    forever #25 i_core_clk = ~i_core_clk;
  end

  // hang guard, well above the longest expected run
  always @(posedge i_core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_mismatch = n_mismatch + 1;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("[ERR] %0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one-cycle write strobe; a gap cycle follows before the next one
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_core_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd   <= 1'b0;
    #1;
    d = o_rdata;
  endtask

  // counts high cycles and rising edges per channel over w cycles
  task automatic meas(input int w);
    logic [1:0] prev;
    hi_c = '{0, 0};
    tr_c = '{0, 0};
    @(posedge i_core_clk);
    #1;
    prev = o_pwm;
    repeat (w) begin
      @(posedge i_core_clk);
      #1;
      for (int c = 0; c < 2; c++) begin
        hi_c[c] = hi_c[c] + o_pwm[c];
        tr_c[c] = tr_c[c] + (o_pwm[c] & ~prev[c]);
      end
      prev = o_pwm;
    end
  endtask

  task automatic setup(input int p, input int ps, input int post);
    per_p = p;
    ps_n  = 1 << (2 * ps);
    wr(`STPWM_ADDR_PERIOD, 8'(p));
    wr(`STPWM_ADDR_TCTL, {1'b0, 4'(post), 2'(ps), 1'b1});
    for (int c = 0; c < 2; c++) begin
      wr(8'h08 + 8'(4 * c), 8'(duty[c] >> 2));
      wr(8'h09 + 8'(4 * c), {2'(duty[c]), 6'($random(seed))});
      wr(8'h0a + 8'(4 * c), {en[c] != 0, 2'b00, inv[c] != 0, 4'h0});
    end
    // restart the count so a shorter period takes hold at once
    wr(`STPWM_ADDR_COUNT, 8'h00);
    repeat (8 * (p + 1) * ps_n) @(posedge i_core_clk);
  endtask

  // model: w is a whole number of periods, so phase does not matter
  task automatic run_check();
    int lim;
    int w;
    int eh;
    int et;
    lim = 4 * (per_p + 1);
    w   = 2 * lim * ps_n;
    meas(w);
    for (int c = 0; c < 2; c++) begin
      eh = 0;
      et = 0;
      if (en[c] != 0 && duty[c] >= lim) begin
        eh = w;
      end else if (en[c] != 0 && duty[c] > 0) begin
        eh = 2 * duty[c] * ps_n;
        et = 2;
      end
      if (inv[c] != 0) eh = w - eh;
      check(hi_c[c], eh);
      check(tr_c[c], et);
      rd(8'h0a + 8'(4 * c), rv);
      if (et == 0) begin
        check(rv & 8'hb0, {en[c] != 0, 1'b0, eh == w, inv[c] != 0, 4'h0});
      end else begin
        check(rv & 8'h90, {en[c] != 0, 2'b00, inv[c] != 0, 4'h0});
      end
    end
  endtask

  initial begin
    int p;
    int ps;
    seed = 32'h4b14d0d5;
    n_mismatch = 0;
    n_checks = 0;
    i_arst_n = 1'b0;
    i_clk_en = 1'b1;
    i_sleep = 1'b0;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    repeat (16) @(posedge i_core_clk);
    check(o_pwm, 2'b00);
    check(o_pin_oe_n, 2'b11);
    i_arst_n <= 1'b1;
    rd(`STPWM_ADDR_PERIOD, rv);
    check(rv, 8'hff);
    rd(`STPWM_ADDR_TCTL, rv);
    check(rv, 8'h00);
    rd(`STPWM_ADDR_DIR, rv);
    check(rv & 8'h03, 8'h03);
    rd(8'h08, rv);
    check(rv, 8'h00);
    rd(8'h0e, rv);
    check(rv & 8'hb0, 8'h00);
    // unmapped places read as zero
    rd(8'h04, rv);
    check(rv, 8'h00);
    rd(8'h40, rv);
    check(rv, 8'h00);
    // strobes with the clock enable low are ignored
    @(posedge i_core_clk);
    i_clk_en <= 1'b0;
    wr(`STPWM_ADDR_PERIOD, 8'h55);
    i_clk_en <= 1'b1;
    rd(`STPWM_ADDR_PERIOD, rv);
    check(rv, 8'hff);
    wr(`STPWM_ADDR_DIR, 8'h01);
    repeat (2) @(posedge i_core_clk);
    #1;
    check(o_pin_oe_n, 2'b01);
    // random periods, prescales, duties and polarities
    for (int k = 0; k < 6; k++) begin
      ps = $random(seed) & 3;
      p = $random(seed) & 7;
      if (ps == 3) p = p & 1;
      for (int c = 0; c < 2; c++) begin
        duty[c] = ($random(seed) & 32'h7fffffff) % (4 * (p + 1) + 1);
        inv[c] = $random(seed) & 1;
        en[c] = 1;
      end
      if (k == 0) duty[0] = 0;
      if (k == 1) duty[1] = 4 * (p + 1);
      if (k == 2) en[1] = 0;
      if (k == 3) begin
        en[0] = 0;
        inv[0] = 1;
      end
      setup(p, ps, $random(seed) & 15);
      run_check();
    end
    // pulse width beyond the period holds the level
    duty = '{20, 5};
    inv = '{0, 0};
    en = '{1, 1};
    setup(3, 0, 0);
    meas(32);
    check(tr_c[0], 0);
    check(32'(hi_c[0] == 0 || hi_c[0] == 32), 32'h1);
    // sleep freezes the count and the outputs, then resumes
    duty = '{5, 11};
    setup(3, 0, 9);
    @(posedge i_core_clk);
    i_sleep <= 1'b1;
    rd(`STPWM_ADDR_COUNT, rv);
    meas(40);
    rd(`STPWM_ADDR_COUNT, rv2);
    check(rv2, rv);
    for (int c = 0; c < 2; c++) begin
      check(tr_c[c], 0);
      check(32'(hi_c[c] == 0 || hi_c[c] == 40), 32'h1);
    end
    i_sleep <= 1'b0;
    repeat (32) @(posedge i_core_clk);
    run_check();
    // second reset in mid-run
    @(posedge i_core_clk);
    i_arst_n <= 1'b0;
    #1;
    check(o_pwm, 2'b00);
    check(o_pin_oe_n, 2'b11);
    repeat (16) @(posedge i_core_clk);
    i_arst_n <= 1'b1;
    rd(`STPWM_ADDR_PERIOD, rv);
    check(rv, 8'hff);
    rd(8'h0c, rv);
    check(rv, 8'h00);
    final_report();
  end
endmodule
`default_nettype wire
